//--- src/cdg_cfg.svh
// Register map, field positions, reset values and ramp counts
`ifndef CDG_CFG_SVH
`define CDG_CFG_SVH
// Behaviour
// - DAC gain 00h mute, 01h -71.625 dB, 0.375 dB steps, C0h 0 dB and reset.
// - A DAC gain write with commit set makes both staged DAC gains active.
// - ADC gain 00h mute, 01h -71.625, 0.375 dB steps, EFh +17.625, reset C0h.
// - An ADC gain write with commit set makes both staged ADC gains active.
// - With unmute ramp set, releasing mute makes DAC gain climb gradually.
// - De-emphasis 00 off, 01/10/11 the 32/44.1/48 kHz curve, reset 00.
// - The soft mute bit silences the DAC path when one and resets to one.
// - Each DAC polarity bit negates that channel's output samples, reset zero.
// - Sidetone gain 0000 -36 dB, 3 dB steps to 1011 -3 dB, 1100 0 dB, reset 0.
// - Sidetone source 00 none, 01 left ADC, 10 right ADC, 11 reserved.
// - The ADC oversample bit gives 128fs when set, 64fs when clear, reset one.
// - The ADC high-pass filter runs when enabled, else bypassed; reset on.
// - Cut-off select picks hi-fi or one of three voice corners, scaled by fs.
// - Each ADC polarity bit negates its channel's output samples, reset zero.
// - Mute ramp steps once per 2 samples when zero, per 32 when one.
// - Without unmute ramp option, releasing mute restores the gain at once.

`define CDG_IDX_DAC_CTRL 6'h0A
`define CDG_IDX_DAC_L 6'h0B
`define CDG_IDX_DAC_R 6'h0C
`define CDG_IDX_SIDE 6'h0D
`define CDG_IDX_ADC_CTRL 6'h0E
`define CDG_IDX_ADC_L 6'h0F
`define CDG_IDX_ADC_R 6'h10
`define CDG_IDX_STATUS 6'h11

`define CDG_COMMIT_BIT 8
`define CDG_DAC_RATE_BIT 7
`define CDG_DAC_UNRAMP_BIT 6
`define CDG_DAC_MUTE_BIT 2
`define CDG_DAC_LINV_BIT 1
`define CDG_DAC_RINV_BIT 0
`define CDG_ADC_OSR_BIT 9
`define CDG_ADC_HIGHPASS_ENABLE_BIT 8
`define CDG_ADC_LINV_BIT 1
`define CDG_ADC_RINV_BIT 0

`define CDG_DAC_CTRL_RST 16'h0004
`define CDG_SIDE_RST 16'h0000
`define CDG_ADC_CTRL_RST 16'h0300
`define CDG_GAIN_RST 8'hC0
`define CDG_DAC_CTRL_MASK 16'h00F7
`define CDG_SIDE_MASK 16'h1FEF
`define CDG_ADC_CTRL_MASK 16'h0363

`define CDG_RAMP_FAST_LAST 5'h01
`define CDG_RAMP_SLOW_LAST 5'h1F
`define CDG_LEVEL_MAX 8'hFF
`define CDG_GAIN_EXP_UNITY 5'h1B
`define CDG_SIDE_BASE 8'h60
`define CDG_SIDE_TOP 4'hC
`define CDG_HPF_SH_HIFI 5'h0B
`define CDG_HPF_SH_V1 5'h04
`define CDG_HPF_SH_V2 5'h03
`define CDG_HPF_SH_V3 5'h02
`define CDG_DEEM_SH_32K 5'h02
`define CDG_DEEM_SH_44K 5'h03
`define CDG_DEEM_SH_48K 5'h03
`define CDG_RESP_OKAY 2'h0
`define CDG_RESP_SLVERR 2'h2
`endif

//--- src/cdg_pkg.sv
// Types shared by the digital gain and sidetone control block
package cdg_pkg;
  typedef logic signed [15:0] cdg_sample_t;
  typedef struct packed {
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    logic [15:0] dac_ctrl;
    logic [15:0] side_ctrl;
    logic [15:0] adc_ctrl;
    logic [7:0] dac_l_stage;
    logic [7:0] dac_r_stage;
    logic [7:0] adc_l_stage;
    logic [7:0] adc_r_stage;
    logic [7:0] dac_l_act;
    logic [7:0] dac_r_act;
    logic [7:0] adc_l_act;
    logic [7:0] adc_r_act;
    logic [7:0] level;
    logic [4:0] ramp_cnt;
    logic signed [15:0] deem_l;
    logic signed [15:0] deem_r;
    logic signed [27:0] hp_l;
    logic signed [27:0] hp_r;
    cdg_sample_t dac_out_l;
    cdg_sample_t dac_out_r;
    cdg_sample_t adc_out_l;
    cdg_sample_t adc_out_r;
  } cdg_state_t;
endpackage

//--- src/cdg_ctrl.sv
// Digital gain, mute ramp, sidetone and filter control with AXI4-Lite regs
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cdg_cfg.svh"
module cdg_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_tick,
  input wire cdg_pkg::cdg_sample_t dac_in_left,
  input wire cdg_pkg::cdg_sample_t dac_in_right,
  input wire cdg_pkg::cdg_sample_t adc_in_left,
  input wire cdg_pkg::cdg_sample_t adc_in_right,
  output cdg_pkg::cdg_sample_t dac_out_left,
  output cdg_pkg::cdg_sample_t dac_out_right,
  output cdg_pkg::cdg_sample_t adc_out_left,
  output cdg_pkg::cdg_sample_t adc_out_right,
  output logic adc_oversample_high
);
  import cdg_pkg::*;

  localparam cdg_state_t RST = '{
    dac_ctrl: `CDG_DAC_CTRL_RST, side_ctrl: `CDG_SIDE_RST,
    adc_ctrl: `CDG_ADC_CTRL_RST, dac_l_stage: `CDG_GAIN_RST,
    dac_r_stage: `CDG_GAIN_RST, adc_l_stage: `CDG_GAIN_RST,
    adc_r_stage: `CDG_GAIN_RST, dac_l_act: `CDG_GAIN_RST,
    dac_r_act: `CDG_GAIN_RST, adc_l_act: `CDG_GAIN_RST,
    adc_r_act: `CDG_GAIN_RST, default: '0};

  cdg_state_t r;
  cdg_state_t nx;

  // 2^(k/16) in Q15, one 0.375 dB step per entry
  function automatic logic [15:0] mant(input logic [3:0] k);
    case (k)
      4'h0: mant = 16'h8000;
      4'h1: mant = 16'h85AB;
      4'h2: mant = 16'h8B96;
      4'h3: mant = 16'h91C4;
      4'h4: mant = 16'h9838;
      4'h5: mant = 16'h9EF5;
      4'h6: mant = 16'hA5FF;
      4'h7: mant = 16'hAD58;
      4'h8: mant = 16'hB505;
      4'h9: mant = 16'hBD09;
      4'hA: mant = 16'hC567;
      4'hB: mant = 16'hCE25;
      4'hC: mant = 16'hD745;
      4'hD: mant = 16'hE0CD;
      4'hE: mant = 16'hEAC1;
      default: mant = 16'hF525;
    endcase
  endfunction

  function automatic cdg_sample_t sat16(input logic signed [40:0] y);
    if (y > 41'sh0_0000_7FFF) begin
      sat16 = 16'sh7FFF;
    end else if (y < -41'sh0_0000_8000) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = y[15:0];
    end
  endfunction

  // Code 0 is silence, C0h unity; upper nibble is the octave-ish exponent
  function automatic cdg_sample_t apply_gain(input cdg_sample_t x,
                                             input logic [7:0] code);
    logic signed [40:0] p;
    logic [4:0] sh;
    p = x * $signed({1'b0, mant(code[3:0])});
    sh = `CDG_GAIN_EXP_UNITY - {1'b0, code[7:4]};
    if (code == 8'h00) begin
      apply_gain = 16'sh0000;
    end else begin
      apply_gain = sat16(p >>> sh);
    end
  endfunction

  // Saturating negate; -32768 has no positive twin
  function automatic cdg_sample_t neg16(input cdg_sample_t x, input logic en);
    if (!en) begin
      neg16 = x;
    end else begin
      neg16 = sat16(-{{25{x[15]}}, x});
    end
  endfunction

  function automatic logic [7:0] side_code(input logic [3:0] s);
    logic [3:0] c;
    c = (s > `CDG_SIDE_TOP) ? `CDG_SIDE_TOP : s;
    side_code = `CDG_SIDE_BASE + {1'b0, c, 3'b000};
  endfunction

  function automatic cdg_sample_t side_pick(input logic [1:0] src,
                                            input cdg_sample_t l,
                                            input cdg_sample_t rr);
    case (src)
      2'b01: side_pick = l;
      2'b10: side_pick = rr;
      default: side_pick = 16'sh0000;
    endcase
  endfunction

  function automatic logic [4:0] hpf_shift(input logic [1:0] cut);
    case (cut)
      2'b00: hpf_shift = `CDG_HPF_SH_HIFI;
      2'b01: hpf_shift = `CDG_HPF_SH_V1;
      2'b10: hpf_shift = `CDG_HPF_SH_V2;
      default: hpf_shift = `CDG_HPF_SH_V3;
    endcase
  endfunction

  function automatic logic [4:0] deem_shift(input logic [1:0] sel);
    case (sel)
      2'b01: deem_shift = `CDG_DEEM_SH_32K;
      2'b10: deem_shift = `CDG_DEEM_SH_44K;
      default: deem_shift = `CDG_DEEM_SH_48K;
    endcase
  endfunction

  // Leaky DC tracker in Q12; corner follows fs since it steps per sample
  function automatic logic signed [27:0] hp_track(input cdg_sample_t x,
                                                 input logic signed [27:0] s,
                                                 input logic [4:0] sh);
    logic signed [28:0] d;
    d = {x[15], x, 12'h000} - {s[27], s};
    hp_track = 28'(s + 28'(d >>> sh));
  endfunction

  function automatic cdg_sample_t one_pole(input cdg_sample_t x,
                                           input cdg_sample_t y,
                                           input logic [4:0] sh);
    logic signed [16:0] d;
    d = {x[15], x} - {y[15], y};
    one_pole = 16'(y + 16'(d >>> sh));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] st);
    merge16 = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [7:0] min8(input logic [7:0] a,
                                      input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

  logic [5:0] widx;
  logic [5:0] ridx;
  logic wr_en;
  logic commit_bit;
  logic [4:0] ramp_last;
  logic ramp_jump;
  cdg_sample_t deem_out_l;
  cdg_sample_t deem_out_r;
  cdg_sample_t adc_pre_l;
  cdg_sample_t adc_pre_r;

  assign widx = r.aw_addr[7:2];
  assign ridx = s_axi_araddr[7:2];
  assign wr_en = r.aw_hold && r.w_hold && !r.bvalid;
  assign commit_bit = r.w_strb[1] && r.w_data[`CDG_COMMIT_BIT];
  assign ramp_last = r.dac_ctrl[`CDG_DAC_RATE_BIT] ? `CDG_RAMP_SLOW_LAST :
                     `CDG_RAMP_FAST_LAST;
  assign ramp_jump = !r.dac_ctrl[`CDG_DAC_MUTE_BIT] &&
                     !r.dac_ctrl[`CDG_DAC_UNRAMP_BIT];
  assign deem_out_l = one_pole(dac_in_left, r.deem_l,
                               deem_shift(r.dac_ctrl[5:4]));
  assign deem_out_r = one_pole(dac_in_right, r.deem_r,
                               deem_shift(r.dac_ctrl[5:4]));
  assign adc_pre_l = neg16(adc_in_left,
                           r.adc_ctrl[`CDG_ADC_LINV_BIT]);
  assign adc_pre_r = neg16(adc_in_right,
                           r.adc_ctrl[`CDG_ADC_RINV_BIT]);

  always_comb begin
    cdg_sample_t pl;
    cdg_sample_t pr;
    cdg_sample_t hl;
    cdg_sample_t hr;
    logic signed [40:0] sl;
    logic signed [40:0] sr;
    nx = r;
    pl = 16'sh0000;
    pr = 16'sh0000;
    hl = 16'sh0000;
    hr = 16'sh0000;
    sl = '0;
    sr = '0;
    // Write channels accepted in either order, held until both present
    if (s_axi_awvalid && !r.aw_hold) begin
      nx.aw_hold = 1'b1;
      nx.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_hold) begin
      nx.w_hold = 1'b1;
      nx.w_data = s_axi_wdata;
      nx.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      nx.bvalid = 1'b0;
    end
    if (wr_en) begin
      nx.aw_hold = 1'b0;
      nx.w_hold = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = `CDG_RESP_OKAY;
      case (widx)
        `CDG_IDX_DAC_CTRL: nx.dac_ctrl = merge16(r.dac_ctrl, r.w_data,
                           r.w_strb) & `CDG_DAC_CTRL_MASK;
        `CDG_IDX_SIDE: nx.side_ctrl = merge16(r.side_ctrl, r.w_data,
                       r.w_strb) & `CDG_SIDE_MASK;
        `CDG_IDX_ADC_CTRL: nx.adc_ctrl = merge16(r.adc_ctrl, r.w_data,
                           r.w_strb) & `CDG_ADC_CTRL_MASK;
        `CDG_IDX_DAC_L, `CDG_IDX_DAC_R: begin
          if (r.w_strb[0] && widx == `CDG_IDX_DAC_L) begin
            nx.dac_l_stage = r.w_data[7:0];
          end
          if (r.w_strb[0] && widx == `CDG_IDX_DAC_R) begin
            nx.dac_r_stage = r.w_data[7:0];
          end
          if (commit_bit) begin
            nx.dac_l_act = nx.dac_l_stage;
            nx.dac_r_act = nx.dac_r_stage;
          end
        end
        `CDG_IDX_ADC_L, `CDG_IDX_ADC_R: begin
          if (r.w_strb[0] && widx == `CDG_IDX_ADC_L) begin
            nx.adc_l_stage = r.w_data[7:0];
          end
          if (r.w_strb[0] && widx == `CDG_IDX_ADC_R) begin
            nx.adc_r_stage = r.w_data[7:0];
          end
          if (commit_bit) begin
            nx.adc_l_act = nx.adc_l_stage;
            nx.adc_r_act = nx.adc_r_stage;
          end
        end
        `CDG_IDX_STATUS: nx.bresp = `CDG_RESP_OKAY;
        default: nx.bresp = `CDG_RESP_SLVERR;
      endcase
    end
    // Read: one outstanding, answered the cycle after the address
    if (r.rvalid && s_axi_rready) begin
      nx.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !r.rvalid) begin
      nx.rvalid = 1'b1;
      nx.rresp = `CDG_RESP_OKAY;
      case (ridx)
        `CDG_IDX_DAC_CTRL: nx.rdata = r.dac_ctrl;
        `CDG_IDX_DAC_L: nx.rdata = {8'h00, r.dac_l_stage};
        `CDG_IDX_DAC_R: nx.rdata = {8'h00, r.dac_r_stage};
        `CDG_IDX_SIDE: nx.rdata = r.side_ctrl;
        `CDG_IDX_ADC_CTRL: nx.rdata = r.adc_ctrl;
        `CDG_IDX_ADC_L: nx.rdata = {8'h00, r.adc_l_stage};
        `CDG_IDX_ADC_R: nx.rdata = {8'h00, r.adc_r_stage};
        `CDG_IDX_STATUS: nx.rdata = {3'h0, r.ramp_cnt, r.level};
        default: begin
          nx.rdata = 16'h0000;
          nx.rresp = `CDG_RESP_SLVERR;
        end
      endcase
    end
    // Mute level ramps one code per ramp period of samples
    if (ramp_jump) begin
      nx.level = `CDG_LEVEL_MAX;
      nx.ramp_cnt = 5'h00;
    end else if (sample_tick) begin
      if (r.ramp_cnt >= ramp_last) begin
        nx.ramp_cnt = 5'h00;
        if (r.dac_ctrl[`CDG_DAC_MUTE_BIT] && r.level != 8'h00) begin
          nx.level = r.level - 8'h01;
        end else if (!r.dac_ctrl[`CDG_DAC_MUTE_BIT] &&
                     r.level != `CDG_LEVEL_MAX) begin
          nx.level = r.level + 8'h01;
        end
      end else begin
        nx.ramp_cnt = r.ramp_cnt + 5'h01;
      end
    end
    // Sample path, registered once per sample
    if (sample_tick) begin
      if (r.dac_ctrl[5:4] != 2'b00) begin
        nx.deem_l = deem_out_l;
        nx.deem_r = deem_out_r;
        pl = deem_out_l;
        pr = deem_out_r;
      end else begin
        pl = dac_in_left;
        pr = dac_in_right;
      end
      sl = 41'(apply_gain(pl, min8(r.dac_l_act, r.level))) +
           41'(apply_gain(side_pick(r.side_ctrl[3:2], r.adc_out_l,
           r.adc_out_r), side_code(r.side_ctrl[12:9])));
      sr = 41'(apply_gain(pr, min8(r.dac_r_act, r.level))) +
           41'(apply_gain(side_pick(r.side_ctrl[1:0], r.adc_out_l,
           r.adc_out_r), side_code(r.side_ctrl[8:5])));
      nx.dac_out_l = neg16(sat16(sl), r.dac_ctrl[`CDG_DAC_LINV_BIT]);
      nx.dac_out_r = neg16(sat16(sr), r.dac_ctrl[`CDG_DAC_RINV_BIT]);
      if (r.adc_ctrl[`CDG_ADC_HIGHPASS_ENABLE_BIT]) begin
        hl = sat16(41'(adc_pre_l) - 41'(r.hp_l >>> 12));
        hr = sat16(41'(adc_pre_r) - 41'(r.hp_r >>> 12));
        nx.hp_l = hp_track(adc_pre_l, r.hp_l, hpf_shift(r.adc_ctrl[6:5]));
        nx.hp_r = hp_track(adc_pre_r, r.hp_r, hpf_shift(r.adc_ctrl[6:5]));
      end else begin
        hl = adc_pre_l;
        hr = adc_pre_r;
      end
      nx.adc_out_l = apply_gain(hl, r.adc_l_act);
      nx.adc_out_r = apply_gain(hr, r.adc_r_act);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= RST;
    end else begin
      r <= nx;
    end
  end

  assign s_axi_awready = !r.aw_hold;
  assign s_axi_wready = !r.w_hold;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = {16'h0000, r.rdata};
  assign dac_out_left = r.dac_out_l;
  assign dac_out_right = r.dac_out_r;
  assign adc_out_left = r.adc_out_l;
  assign adc_out_right = r.adc_out_r;
  assign adc_oversample_high = r.adc_ctrl[`CDG_ADC_OSR_BIT];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic dac_commit_wr;
  logic adc_commit_wr;
  assign dac_commit_wr = wr_en && commit_bit &&
    (widx == `CDG_IDX_DAC_L || widx == `CDG_IDX_DAC_R);
  assign adc_commit_wr = wr_en && commit_bit &&
    (widx == `CDG_IDX_ADC_L || widx == `CDG_IDX_ADC_R);

  sequence s_dac_commit;
    dac_commit_wr;
  endsequence

  a_dac_commit_pair: assert property (s_dac_commit |=>
    r.dac_l_act == r.dac_l_stage && r.dac_r_act == r.dac_r_stage)
    else $error("DAC gains not committed together");
  a_adc_commit_pair: assert property (adc_commit_wr |=>
    r.adc_l_act == r.adc_l_stage && r.adc_r_act == r.adc_r_stage)
    else $error("ADC gains not committed together");
  a_stage_no_effect: assert property (!dac_commit_wr &&
    !adc_commit_wr |=>
    $stable({r.dac_l_act, r.dac_r_act, r.adc_l_act, r.adc_r_act}))
    else $error("Active gain changed without commit");
  a_mute_from_reset: assert property ($fell(reset) |->
    r.dac_ctrl[`CDG_DAC_MUTE_BIT] && adc_oversample_high)
    else $error("Mute or oversample not set after reset");
  a_unmute_jump: assert property (ramp_jump |=>
    r.level == `CDG_LEVEL_MAX)
    else $error("Level did not jump on unmute");
  sequence s_climb_step;
    !r.dac_ctrl[`CDG_DAC_MUTE_BIT] && r.dac_ctrl[`CDG_DAC_UNRAMP_BIT] &&
    sample_tick && r.ramp_cnt == ramp_last && r.level != `CDG_LEVEL_MAX;
  endsequence
  a_unmute_climb: assert property (s_climb_step |=>
    r.level == $past(r.level) + 8'h01)
    else $error("Unmute ramp did not climb one step");
  a_ramp_pace: assert property (!ramp_jump && $changed(r.level) |->
    $past(sample_tick) && $past(r.ramp_cnt) >= $past(ramp_last))
    else $error("Level moved off the ramp period");
  a_dac_silence: assert property (sample_tick &&
    r.dac_l_act == 8'h00 && r.side_ctrl[3:2] == 2'b00 |=>
    dac_out_left == 16'sh0000)
    else $error("DAC code zero not silent");
  a_adc_silence: assert property (sample_tick &&
    r.adc_r_act == 8'h00 |=> adc_out_right == 16'sh0000)
    else $error("ADC code zero not silent");
  a_hpf_bypass: assert property (sample_tick &&
    !r.adc_ctrl[`CDG_ADC_HIGHPASS_ENABLE_BIT] && !r.adc_ctrl[`CDG_ADC_LINV_BIT] &&
    r.adc_l_act == `CDG_GAIN_RST |=> adc_out_left == $past(adc_in_left))
    else $error("Bypassed ADC path not transparent");
  a_adc_invert: assert property (sample_tick &&
    !r.adc_ctrl[`CDG_ADC_HIGHPASS_ENABLE_BIT] && r.adc_ctrl[`CDG_ADC_LINV_BIT] &&
    r.adc_l_act == `CDG_GAIN_RST && adc_in_left != 16'sh8000 |=>
    adc_out_left == -$past(adc_in_left))
    else $error("ADC left not inverted");
  a_dac_invert: assert property (sample_tick &&
    r.dac_ctrl[5:4] == 2'b00 && r.dac_ctrl[`CDG_DAC_RINV_BIT] &&
    r.level == `CDG_LEVEL_MAX && r.dac_r_act == `CDG_GAIN_RST &&
    r.side_ctrl[1:0] == 2'b00 && dac_in_right != 16'sh8000 |=>
    dac_out_right == -$past(dac_in_right))
    else $error("DAC right not inverted");
endmodule
`default_nettype wire

//--- bench/cdg_ctrl_tb.sv
// Self-checking testbench for the digital gain and sidetone control block
`timescale 1ns/1ps
`default_nettype none
module cdg_ctrl_tb;
  import cdg_pkg::*;
  typedef struct {
    logic [7:0] a;
    logic [15:0] r;
    logic [15:0] w;
    logic [15:0] d;
  } cdg_row_t;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic tick = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, osr;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  cdg_sample_t di_l = 16'h0000;
  cdg_sample_t di_r = 16'h0000;
  cdg_sample_t ai_l = 16'h0000;
  cdg_sample_t ai_r = 16'h0000;
  cdg_sample_t do_l, do_r, ao_l, ao_r;
  int err_count = 0;
  int n_compared = 0;
  // Mapped rows in address order, then the read-only status word
  cdg_row_t rows [8] = '{'{8'h28, 16'h0004, 16'hFFFF, 16'h00F7},
    '{8'h2C, 16'h00C0, 16'h01A5, 16'h00A5},
    '{8'h30, 16'h00C0, 16'h005A, 16'h005A},
    '{8'h34, 16'h0000, 16'hFFFF, 16'h1FEF},
    '{8'h38, 16'h0300, 16'hFFFF, 16'h0363},
    '{8'h3C, 16'h00C0, 16'h0133, 16'h0033},
    '{8'h40, 16'h00C0, 16'h0044, 16'h0044},
    '{8'h44, 16'h0000, 16'hFFFF, 16'h0000}};

  always #50 mclk = ~mclk;

  cdg_ctrl i_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_tick(tick), .dac_in_left(di_l), .dac_in_right(di_r),
    .adc_in_left(ai_l), .adc_in_right(ai_r), .dac_out_left(do_l),
    .dac_out_right(do_r), .adc_out_left(ao_l), .adc_out_right(ao_r),
    .adc_oversample_high(osr));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task final_report;
    $display("Compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task do_reset;
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
  endtask

  // Address and data offered together, each dropped once taken
  task wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {16'h0000, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    chk("write answered", bvalid, 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    chk("read answered", rvalid, 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // One sample tick; outputs are looked at once the taking edge settled
  task smp(input cdg_sample_t dl, input cdg_sample_t dr);
    @(posedge mclk);
    di_l <= dl;
    di_r <= dr;
    ai_l <= 16'sd300;
    ai_r <= 16'sd400;
    tick <= 1'b1;
    @(posedge mclk);
    tick <= 1'b0;
    #1;
  endtask

  initial begin
    #3000000;
    chk("watchdog", 1'b1, 1'b0);
    final_report();
  end

  initial begin
    do_reset();
    chk("oversample after reset", osr, 1'b1);
    foreach (rows[i]) begin
      rdr(rows[i].a);
      chk("reset value", rd, rows[i].r);
      wr(rows[i].a, rows[i].w);
      chk("write response", resp, 2'h0);
      rdr(rows[i].a);
      chk("readback", rd, rows[i].d);
    end
    chk("oversample set", osr, 1'b1);
    wr(8'h48, 16'h1234);
    chk("unmapped write resp", resp, 2'h2);
    rdr(8'h48);
    chk("unmapped read resp", resp, 2'h2);
    chk("unmapped read data", rd, 32'h00000000);
    wr(8'h38, 16'h0000);
    chk("oversample cleared", osr, 1'b0);
    $display("Test register table done");
    // Second reset in mid-run, then the sample path
    do_reset();
    wr(8'h38, 16'h0202);
    smp(16'sd1000, 16'sd2000);
    chk("dac left muted", do_l, 16'sd0);
    chk("adc left inverted", ao_l, -16'sd300);
    chk("adc right plain", ao_r, 16'sd400);
    wr(8'h34, 16'h1804);
    wr(8'h28, 16'h0000);
    smp(16'sd1000, 16'sd2000);
    chk("dac left sidetone", do_l, 16'sd700);
    chk("dac right no sidetone", do_r, 16'sd2000);
    $display("Test unmute and sidetone done");
    wr(8'h34, 16'h0000);
    wr(8'h28, 16'h0003);
    smp(16'sd1000, 16'sd2000);
    chk("dac left negated", do_l, -16'sd1000);
    chk("dac right negated", do_r, -16'sd2000);
    wr(8'h2C, 16'h0000);
    smp(16'sd1000, 16'sd2000);
    chk("dac left staged only", do_l, -16'sd1000);
    wr(8'h30, 16'h0100);
    smp(16'sd1000, 16'sd2000);
    chk("dac left committed", do_l, 16'sd0);
    chk("dac right committed", do_r, 16'sd0);
    wr(8'h3C, 16'h0000);
    smp(16'sd1000, 16'sd2000);
    chk("adc left staged only", ao_l, -16'sd300);
    wr(8'h40, 16'h0100);
    smp(16'sd1000, 16'sd2000);
    chk("adc left committed", ao_l, 16'sd0);
    chk("adc right committed", ao_r, 16'sd0);
    $display("Test staging and commit done");
    // Ramped unmute climbs from silence, fast then slow rate
    for (int i = 0; i < 2; i++) begin
      do_reset();
      wr(8'h28, (i == 1) ? 16'h00C0 : 16'h0040);
      repeat (8) smp(16'sd1000, 16'sd2000);
      chk("ramp output below input", do_l < 16'sd1000, 1'b1);
      rdr(8'h44);
      chk("ramp level", (i == 1) ? rd[7:0] <= 8'h01
        : (rd[7:0] >= 8'h03 && rd[7:0] <= 8'h05), 1'b1);
    end
    $display("Test unmute ramp done");
    // Filters on a steady input: high-pass sinks DC, de-emphasis lags
    do_reset();
    wr(8'h38, 16'h0360);
    wr(8'h28, 16'h0010);
    repeat (2) smp(16'sd1000, 16'sd2000);
    chk("hpf removes dc", ao_l < 16'sd300, 1'b1);
    chk("hpf output positive", ao_l > 16'sd0, 1'b1);
    chk("deemphasis lags", do_l < 16'sd1000, 1'b1);
    chk("deemphasis passes", do_l > 16'sd0, 1'b1);
    $display("Test filters done");
    final_report();
  end
endmodule
`default_nettype wire
